// *** rtl/rcsw_top.sv ***
// Run/stop command source arbitration and 2/3-wire terminal decode, Wishbone slave.
// Assumes terminal, keypad and serial inputs already synchronous to clk_i.
// Contract
// - Remote source 0..6 selects run origin
// - Local source setting selects run origin
// - Odd settings let keypad stop act
// - Keypad source uses run, stop, jog keys
// - Reset returns selection to remote
// - Local/remote input overrides keypad selection
// - Source change while running ramps stop
// - Start only on start command edge
// - Wire mode selects terminal decode
// - Three-wire locks first input as stop
// - Wire mode write refused while running
// - Terminal transition re-evaluates combined state
// - Mode 0 forward xor reverse runs
// - Mode 0 after fault needs edge
// - Mode 1 run level, direction level
// - Mode 1 after fault cycle run
// - Three-wire momentary run, stop overrides
// - Open stop contact stops, reclose with run held restarts
// - Three-wire direction is maintained level
// - Three-wire after fault needs terminal change
// - Terminal roles fixed by wire mode
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rcsw_cfg.svh"
module rcsw_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire rcsw_pkg::rcsw_term_t term_i,
	input wire logic key_run_i,
	input wire logic key_stop_i,
	input wire logic key_jog_i,
	input wire logic key_local_toggle_i,
	input wire rcsw_pkg::rcsw_cmd_t serial_cmd_i,
	input wire rcsw_pkg::rcsw_cmd_t card_cmd_i,
	input wire logic mfi_lr_en_i,
	input wire logic mfi_lr_level_i,
	input wire logic ext_fault_reset_i,
	output logic run_o,
	output logic rev_o,
	output logic jog_o,
	output logic local_o,
	output logic di1_stop_locked_o
);
	// ****************************************
	// Register file
	// ****************************************
	logic [15:0] remote_src_q;
	logic [15:0] local_src_q;
	logic [15:0] wire_mode_q;
	logic behav_q;
	logic kp_local_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic run_q;
	logic rev_q;
	logic jog_q;
	logic local_q;
	logic lock_q;
	logic block_q;

	// Word index is byte address divided by four
	wire [13:0] word_idx = wb_adr_i[15:2];
	wire req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr = req & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
	wire hit_rsrc = word_idx == {2'b00, `RCSW_IDX_REMOTE_SRC};
	wire hit_lsrc = word_idx == {2'b00, `RCSW_IDX_LOCAL_SRC};
	wire hit_wire = word_idx == {2'b00, `RCSW_IDX_WIRE_MODE};
	wire hit_ctl = word_idx == {2'b00, `RCSW_IDX_CONTROL};
	wire hit_st = word_idx == {2'b00, `RCSW_IDX_STATUS};
	wire [15:0] wdat = wb_dat_i[15:0];
	wire src_ok = wdat <= `RCSW_SRC_MAX;
	wire wire_ok = wdat <= `RCSW_WIRE_MAX;
	wire wr_rsrc = wr & hit_rsrc & src_ok;
	wire wr_lsrc = wr & hit_lsrc & src_ok;
	wire wr_wire = wr & hit_wire & wire_ok & ~run_q;
	wire wr_ctl = wr & hit_ctl;

	wire [15:0] status_w = {11'h000, block_q, lock_q, local_q, rev_q, run_q};
	wire [15:0] rsel = hit_rsrc ? remote_src_q :
		hit_lsrc ? local_src_q :
		hit_wire ? wire_mode_q :
		hit_ctl ? {14'h0000, kp_local_q, behav_q} :
		hit_st ? status_w : 16'h0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remote_src_q <= `RCSW_RST_SRC;
			local_src_q <= `RCSW_RST_SRC;
			wire_mode_q <= `RCSW_RST_WIRE;
			behav_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			rdat_q <= {16'h0000, rsel};
			if (wr_rsrc) remote_src_q <= wdat;
			if (wr_lsrc) local_src_q <= wdat;
			if (wr_wire) wire_mode_q <= wdat;
			if (wr_ctl) behav_q <= wdat[`RCSW_CTL_BEHAV_BIT];
		end
	end

	// ****************************************
	// Local/remote selection
	// ****************************************
	// Keypad toggle bit comes back to remote on every reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			kp_local_q <= 1'b0;
		end else if (wr_ctl) begin
			kp_local_q <= wdat[`RCSW_CTL_LOCAL_BIT];
		end else if (key_local_toggle_i) begin
			kp_local_q <= ~kp_local_q;
		end
	end

	wire local_w = mfi_lr_en_i ? mfi_lr_level_i : kp_local_q;
	wire [15:0] sel_src = local_w ? local_src_q : remote_src_q;
	wire [2:0] sel3 = sel_src[2:0];
	// Settings 1..6 pair as (1,2) terminals, (3,4) serial, (5,6) card
	wire [1:0] src_kind = (sel3 == 3'd0) ? 2'd0 : 2'(({1'b0, sel3} + 4'd1) >> 1);
	wire kp_stop_ok = (sel3 == 3'd0) | sel3[0];
	wire is_term = src_kind == rcsw_pkg::RCSW_SRC_TERM;
	wire [1:0] wmode = wire_mode_q[1:0];
	wire three_w = wmode == rcsw_pkg::RCSW_WIRE_3W;

	// ****************************************
	// Terminal decode
	// ****************************************
	rcsw_pkg::rcsw_term_t term_q;
	logic src_chg_q;
	logic prev_local_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_q <= 3'b000;
			prev_local_q <= 1'b0;
		end else begin
			term_q <= term_i;
			prev_local_q <= local_w;
		end
	end
	wire term_chg = term_q != term_i;
	wire fwd_rise = term_i.fwd & ~term_q.fwd;
	wire src_switch = prev_local_q != local_w;

	// Forward and reverse roles come from wire mode only
	logic t_run;
	logic t_rev;
	logic t_start;
	always_comb begin
		t_run = 1'b0;
		t_rev = 1'b0;
		t_start = 1'b0;
		case (wmode)
			rcsw_pkg::RCSW_WIRE_2FR: begin
				t_run = term_i.fwd ^ term_i.rev;
				t_rev = term_i.rev;
				t_start = t_run & term_chg;
			end
			rcsw_pkg::RCSW_WIRE_2RD: begin
				t_run = term_i.fwd;
				t_rev = term_i.rev;
				t_start = fwd_rise;
			end
			rcsw_pkg::RCSW_WIRE_3W: begin
				t_run = term_i.di1;
				t_rev = term_i.rev;
				// Reclosing stop with run held restarts as well
				t_start = term_i.di1 & term_i.fwd & (fwd_rise | (term_i.di1 & ~term_q.di1));
			end
			default: begin
				t_run = 1'b0;
				t_rev = 1'b0;
				t_start = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Per-source commands
	// ****************************************
	logic key_run_q;
	logic ser_run_q;
	logic card_run_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_run_q <= 1'b0;
			ser_run_q <= 1'b0;
			card_run_q <= 1'b0;
		end else begin
			key_run_q <= key_run_i;
			ser_run_q <= serial_cmd_i.run;
			card_run_q <= card_cmd_i.run;
		end
	end

	logic c_start;
	logic c_stop;
	logic c_rev;
	logic c_keep;
	always_comb begin
		c_start = 1'b0;
		c_stop = 1'b0;
		c_rev = rev_q;
		c_keep = 1'b1;
		case (src_kind)
			rcsw_pkg::RCSW_SRC_KEYPAD: begin
				c_start = key_run_i & ~key_run_q;
				c_stop = key_stop_i;
			end
			rcsw_pkg::RCSW_SRC_TERM: begin
				c_start = t_start;
				c_stop = ~t_run;
				c_rev = t_rev;
				c_keep = t_run & (~three_w | term_i.di1);
			end
			rcsw_pkg::RCSW_SRC_SERIAL: begin
				c_start = serial_cmd_i.run & ~ser_run_q;
				c_stop = serial_cmd_i.stop;
				c_rev = serial_cmd_i.rev;
			end
			rcsw_pkg::RCSW_SRC_CARD: begin
				c_start = card_cmd_i.run & ~card_run_q;
				c_stop = card_cmd_i.stop;
				c_rev = card_cmd_i.rev;
			end
			default: begin
				c_start = 1'b0;
				c_stop = 1'b1;
			end
		endcase
	end

	wire kp_stop_hit = key_stop_i & kp_stop_ok & (src_kind != rcsw_pkg::RCSW_SRC_KEYPAD);
	// Behaviour 0 forces a ramp stop on source change; nonzero keeps running
	wire chg_stop = src_switch & ~behav_q;
	wire stop_now = c_stop | ~c_keep | kp_stop_hit | chg_stop;
	// A fault reset blocks terminals until they move; in mode 1 until forward rises
	wire unblock = is_term & term_chg;
	wire unblock_rd = wmode == rcsw_pkg::RCSW_WIRE_2RD ? fwd_rise : unblock;
	wire start_ok = c_start & ~(block_q & is_term & ~unblock_rd);

	// ****************************************
	// Run state and outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= 1'b0;
			rev_q <= 1'b0;
			jog_q <= 1'b0;
			local_q <= 1'b0;
			lock_q <= 1'b0;
			block_q <= 1'b0;
		end else begin
			local_q <= local_w;
			lock_q <= three_w;
			jog_q <= (src_kind == rcsw_pkg::RCSW_SRC_KEYPAD) & key_jog_i & ~run_q;
			if (ext_fault_reset_i) begin
				block_q <= 1'b1;
			end else if (unblock_rd) begin
				block_q <= 1'b0;
			end
			if (ext_fault_reset_i | stop_now) begin
				run_q <= 1'b0;
			end else if (start_ok) begin
				run_q <= 1'b1;
			end
			rev_q <= c_rev;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign run_o = run_q;
	assign rev_o = rev_q;
	assign jog_o = jog_q;
	assign local_o = local_q;
	assign di1_stop_locked_o = lock_q;
endmodule
`default_nettype wire

// *** rtl/rcsw_cfg.svh ***
// Offsets, reset values and field codes of the run command block.
// Assumes inclusion by bare name from the design file.
`ifndef RCSW_CFG_SVH
`define RCSW_CFG_SVH
`define RCSW_IDX_REMOTE_SRC 12'h0300
`define RCSW_IDX_LOCAL_SRC 12'h0301
`define RCSW_IDX_WIRE_MODE 12'h0302
`define RCSW_IDX_CONTROL 12'h0310
`define RCSW_IDX_STATUS 12'h0311
`define RCSW_RST_SRC 16'h0000
`define RCSW_RST_WIRE 16'h0000
`define RCSW_SRC_MAX 16'h0006
`define RCSW_WIRE_MAX 16'h0002
`define RCSW_MFI_LOCAL_REMOTE 8'h21
`define RCSW_CTL_BEHAV_BIT 0
`define RCSW_CTL_LOCAL_BIT 1
`define RCSW_ST_RUN_BIT 0
`define RCSW_ST_REV_BIT 1
`define RCSW_ST_LOCAL_BIT 2
`define RCSW_ST_DI1_LOCK_BIT 3
`define RCSW_ST_BLOCK_BIT 4
`endif

// *** rtl/rcsw_pkg.sv ***
// Types shared by the run command block.
// Assumes the cfg header is on the include path.
package rcsw_pkg;
	typedef enum logic [1:0] {
		RCSW_SRC_KEYPAD = 2'b00,
		RCSW_SRC_TERM = 2'b01,
		RCSW_SRC_SERIAL = 2'b10,
		RCSW_SRC_CARD = 2'b11
	} rcsw_src_t;

	typedef enum logic [1:0] {
		RCSW_WIRE_2FR = 2'b00,
		RCSW_WIRE_2RD = 2'b01,
		RCSW_WIRE_3W = 2'b10
	} rcsw_wire_t;

	// Start/stop/direction request from one command source
	typedef struct packed {
		logic run;
		logic stop;
		logic rev;
	} rcsw_cmd_t;

	// External terminal levels, closed = 1
	typedef struct packed {
		logic fwd;
		logic rev;
		logic di1;
	} rcsw_term_t;
endpackage

// *** verification/rcsw_top_props.sv ***
// Port checker for the run command block.
// Assumes binding onto rcsw_top, one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module rcsw_top_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire rcsw_pkg::rcsw_term_t term_i,
	input wire logic key_run_i,
	input wire logic mfi_lr_en_i,
	input wire logic mfi_lr_level_i,
	input wire logic ext_fault_reset_i,
	input wire logic run_o,
	input wire logic jog_o,
	input wire logic local_o,
	input wire logic di1_stop_locked_o
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [3:0] st = {term_i, key_run_i};
	ack_time_a: assert property (req |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	rd_high_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("rd hi");
	boot_remote_a: assert property ($fell(rst_i) |-> !local_o) else $error("boot");
	mfi_first_a: assert property (mfi_lr_en_i |=> local_o == $past(mfi_lr_level_i))
		else $error("mfi");
	edge_start_a: assert property ($rose(run_o) |-> $past(st) != $past(st, 2))
		else $error("level start");
	stop_open_a: assert property (di1_stop_locked_o && !term_i.di1 |=> !run_o)
		else $error("stop open");
	fault_stop_a: assert property (ext_fault_reset_i |=> !run_o)
		else $error("fault");
	swap_stop_a: assert property (local_o != $past(local_o) |-> ##[0:1] !run_o)
		else $error("swap");
	jog_idle_a: assert property (jog_o |-> !run_o) else $error("jog");
	cover property ($rose(run_o));
	cover property (di1_stop_locked_o && run_o);
	cover property ($rose(local_o));
endmodule
bind rcsw_top rcsw_top_props rcsw_top_props_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.term_i(term_i), .key_run_i(key_run_i), .mfi_lr_en_i(mfi_lr_en_i),
	.mfi_lr_level_i(mfi_lr_level_i), .ext_fault_reset_i(ext_fault_reset_i),
	.run_o(run_o), .jog_o(jog_o), .local_o(local_o), .di1_stop_locked_o(di1_stop_locked_o));
`default_nettype wire

// *** verification/rcsw_far_side.sv ***
// Switch panel, keypad and serial masters facing the block.
// Assumes the bench sets the wanted contact levels.
`timescale 1ns/1ns
`default_nettype none
module rcsw_far_side (
	input wire logic clk_i,
	input wire logic [11:0] panel_i,
	output var rcsw_pkg::rcsw_term_t term_o,
	output var logic key_run_o,
	output var logic key_stop_o,
	output var logic key_jog_o,
	output var rcsw_pkg::rcsw_cmd_t serial_o,
	output var rcsw_pkg::rcsw_cmd_t card_o
);
	logic [11:0] q;
	// Contacts settle a cycle late; stop contact held as asked
	always_ff @(posedge clk_i) q <= panel_i;
	assign {term_o, key_run_o, key_stop_o, key_jog_o, serial_o, card_o} = q;
endmodule
`default_nettype wire

// *** verification/test_run_command_source_and_wire_logic.sv ***
// Self-checking bench for the run command block.
// Assumes rcsw_top, its checker and the panel model.
`timescale 1ns/1ns
`default_nettype none
module test_run_command_source_and_wire_logic;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, kr, ks, kj;
	logic mfe = 0, mfl = 0, flt = 0, tgl = 0, run, rev, jog, loc, lck;
	logic [15:0] adr = 0, src, v;
	logic [31:0] dat = 0, rd, dat_o;
	logic [11:0] panel = 0;
	rcsw_pkg::rcsw_term_t term;
	rcsw_pkg::rcsw_cmd_t ser, crd;
	int errors = 0, num_checks = 0;
	rcsw_far_side rcsw_far_side_i (.clk_i(clk_i), .panel_i(panel), .term_o(term),
		.key_run_o(kr), .key_stop_o(ks), .key_jog_o(kj), .serial_o(ser), .card_o(crd));
	rcsw_top rcsw_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .term_i(term), .key_run_i(kr), .key_stop_i(ks), .key_jog_i(kj),
		.key_local_toggle_i(tgl), .serial_cmd_i(ser), .card_cmd_i(crd),
		.mfi_lr_en_i(mfe), .mfi_lr_level_i(mfl), .ext_fault_reset_i(flt), .run_o(run),
		.rev_o(rev), .jog_o(jog), .local_o(loc), .di1_stop_locked_o(lck));
	// ****
	// Helpers
	// ****
	task chk(string n, logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask
	task tally_and_finish;
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wb(logic w, logic [15:0] a, logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		if (n >= 20) begin
			errors++;
			tally_and_finish;
		end
		cyc <= 0;
		@(posedge clk_i);
	endtask
	task pn(logic [11:0] p);
		panel <= p;
		repeat (3) @(posedge clk_i);
	endtask
	function logic [1:0] exp0(logic f, logic r);
		return {f ^ r, r & ~f};
	endfunction
	// ****
	// Sequence
	// ****
	initial forever #25 clk_i = ~clk_i;
	initial begin
		void'($urandom(25));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (int i = 0; i < 5; i++) begin
			wb(0, i < 3 ? 16'h0c00 + 16'(i * 4) : 16'h0c40 + 16'((i - 3) * 4), 0);
			chk("reset", rd, 0);
		end
		chk("local", loc, 0);
		tgl <= 1;
		@(posedge clk_i);
		tgl <= 0;
		repeat (2) @(posedge clk_i);
		chk("toggle", loc, 1);
		wb(0, 16'h0c40, 0);
		chk("ctl", rd, 2);
		wb(1, 16'h0c40, 0);
		chk("ctl clr", loc, 0);
		src = 0;
		for (int i = 0; i < 8; i++) begin
			v = i < 2 ? 16'(7 - i) : 16'($urandom_range(9));
			wb(1, 16'h0c00, {16'h0000, v});
			src = v <= 16'h0006 ? v : src;
			wb(0, 16'h0c00, 0);
			chk("remote", rd, {16'h0000, src});
		end
		wb(1, 16'h0c08, 3);
		wb(0, 16'h0c08, 0);
		chk("wire", rd, 0);
		wb(1, 16'h0c00, 0);
		pn(12'h100);
		chk("key run", run, 1);
		pn(12'h080);
		chk("key stop", run, 0);
		pn(12'h040);
		chk("jog", jog, 1);
		pn(12'h800);
		wb(1, 16'h0c00, 2);
		repeat (3) @(posedge clk_i);
		chk("held", run, 0);
		for (int s = 1; s < 3; s++) begin
			wb(1, 16'h0c00, s);
			pn(0);
			pn(12'h800);
			pn(12'h880);
			chk("kstop", run, s == 2);
		end
		wb(1, 16'h0c08, 2);
		wb(0, 16'h0c08, 0);
		chk("wire run", rd, 0);
		for (int i = 3; i >= 0; i--) begin
			pn({i[1:0] ^ 2'b01, 10'h000});
			chk("mode0", {run, run & rev}, exp0(i[1], ~i[0]));
		end
		pn(0);
		wb(1, 16'h0c08, 1);
		pn(12'h800);
		chk("mode1", {run, rev}, 2'b10);
		pn(12'hc00);
		chk("mode1 rev", {run, rev}, 2'b11);
		flt <= 1;
		@(posedge clk_i);
		flt <= 0;
		pn(12'hc00);
		chk("fault", run, 0);
		pn(12'h400);
		pn(12'hc00);
		chk("recycle", run, 1);
		pn(0);
		wb(1, 16'h0c08, 2);
		chk("lock", lck, 1);
		pn(12'h200);
		pn(12'ha00);
		chk("3w run", run, 1);
		pn(12'h800);
		chk("3w stop", run, 0);
		pn(12'ha00);
		chk("reclose", run, 1);
		pn(12'he00);
		chk("3w rev", rev, 1);
		mfe <= 1;
		mfl <= 1;
		repeat (3) @(posedge clk_i);
		chk("mfi", {loc, run}, 2'b10);
		pn(12'h300);
		chk("local key", run, 1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
